/* common/dam_pkg.sv */
// package: register map, field positions, reset values and carrier types
// Behaviour
// - datapath_config bit 4 set suppresses packet audio on the video pins, clear lets it out.
// - datapath_config bits 4..0 are reloaded from the remote serializer while bit 7 is clear.
// - datapath_config bit 7 set blocks forward-channel loading and keeps local values.
// - with receive mode bit 5 clear, bit 3 set makes the 4-channel audio enable follow bit 0, bit 3 clear forces it off.
// - datapath_config bit 2 set selects 18-bit video, clear selects 24-bit video.
// - surround audio in repeater mode with 18-bit video is unsupported and is refused.
// - datapath_config bit 1 set selects in-band audio transport, clear selects data-island.
// - with receive mode bit 5 clear and bit 3 set, datapath_config bit 0 set enables 4-channel audio, clear disables it.
// - with the fast bit clear, receive mode bit 6 picks 5 Mbps (0) or 10 Mbps (1).
// - receive mode bit 4 set runs the return link at 20 Mbps and ignores bit 6.
// - receive mode bit 5 enables automatic audio mode from aux codes and resets to 1.
// - the return link fast bit is loaded from the strap pin at reset.
// - receive mode bit 3 selects coax (1) or twisted pair (0) and is loaded from the strap.
// - receive mode bit 2 is read-only and reports the repeater strap.
package dam_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] DATAPATH_CONFIG_IDX = 6'h22;
    localparam logic [5:0] RECEIVE_MODE_STATE_IDX = 6'h23;
    // datapath_config fields
    localparam int DPC_HOLD_BIT = 7;
    localparam int DPC_SUPPRESS_BIT = 4;
    localparam int DPC_OVR4_BIT = 3;
    localparam int DPC_V18_BIT = 2;
    localparam int DPC_INBAND_BIT = 1;
    localparam int DPC_FOURCH_BIT = 0;
    localparam logic [7:0] DPC_RESET = 8'h00;
    localparam logic [7:0] DPC_FC_MASK = 8'h1f;
    // receive_mode_state fields
    localparam int RMS_RATE_BIT = 6;
    localparam int RMS_AUTO_BIT = 5;
    localparam int RMS_FAST_BIT = 4;
    localparam int RMS_COAX_BIT = 3;
    localparam int RMS_RPT_BIT = 2;
    localparam logic RMS_RATE_RESET = 1'b0;
    localparam logic RMS_AUTO_RESET = 1'b1;

    typedef enum logic [1:0] {
        DAM_RATE_5M = 2'b00,
        DAM_RATE_10M = 2'b01,
        DAM_RATE_20M = 2'b10
    } dam_rate_type;

    // strap levels decoded from the strap pin
    typedef struct packed {
        logic fast;
        logic coax;
        logic repeater;
    } dam_strap_type;

    // forward-channel load from the remote serializer
    typedef struct packed {
        logic valid;
        logic [4:0] bits;
    } dam_fc_type;
endpackage

/* design/dam_regs.sv */
// module: datapath and receive mode registers behind a wishbone slave
`timescale 1ns/100ps
module dam_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire dam_pkg::dam_strap_type strap_select_pin_i,
    input wire dam_pkg::dam_fc_type fc_load_i,
    input wire logic aux_code_valid_i,
    input wire logic aux_four_ch_i,
    output logic suppress_packet_audio_on_video_o,
    output logic four_ch_audio_o,
    output logic surround_refused_o,
    output logic video_18bit_o,
    output logic inband_audio_o,
    output dam_pkg::dam_rate_type return_link_rate_o,
    output logic coax_mode_o,
    output logic repeater_mode_o
);
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] dpc_q;
    logic rate_q;
    logic auto_q;
    logic fast_q;
    logic coax_q;
    logic rpt_q;
    logic aux4_q;

    // bus decode; writes land on the edge that the master sees ack
    wire req = cyc_i & stb_i;
    wire [5:0] idx = adr_i[7:2];
    wire hit_dpc = idx == dam_pkg::DATAPATH_CONFIG_IDX;
    wire hit_rms = idx == dam_pkg::RECEIVE_MODE_STATE_IDX;
    wire wr_now = req & we_i & ack_q & sel_i[0];
    wire wr_dpc = wr_now & hit_dpc;
    wire wr_rms = wr_now & hit_rms;
    wire hold = dpc_q[dam_pkg::DPC_HOLD_BIT];
    wire fc_take = fc_load_i.valid & ~hold;

    // receive mode view; reserved bits stay zero
    wire [7:0] rms_view = {1'b0, rate_q, auto_q, fast_q, coax_q, rpt_q, 2'b00};
    wire [7:0] rd_byte = hit_dpc ? dpc_q : (hit_rms ? rms_view : 8'h00);

    // forward load merges into the low five bits; software write wins
    wire [7:0] dpc_fc = (dpc_q & ~dam_pkg::DPC_FC_MASK) | {3'b000, fc_load_i.bits};
    wire [7:0] dpc_d = wr_dpc ? dat_i[7:0] : (fc_take ? dpc_fc : dpc_q);

    // ack for one cycle per request, read data sampled with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // datapath_config storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dpc_q <= dam_pkg::DPC_RESET;
        end else begin
            dpc_q <= dpc_d;
        end
    end

    // strap bits are caught while reset is held, sync reset makes that legal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_q <= strap_select_pin_i.fast;
            coax_q <= strap_select_pin_i.coax;
            rpt_q <= strap_select_pin_i.repeater;
        end else if (wr_rms) begin
            fast_q <= dat_i[dam_pkg::RMS_FAST_BIT];
            coax_q <= dat_i[dam_pkg::RMS_COAX_BIT];
        end
    end

    // rate select and auto audio, plus the last aux code seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_q <= dam_pkg::RMS_RATE_RESET;
            auto_q <= dam_pkg::RMS_AUTO_RESET;
            aux4_q <= 1'b0;
        end else begin
            if (wr_rms) begin
                rate_q <= dat_i[dam_pkg::RMS_RATE_BIT];
                auto_q <= dat_i[dam_pkg::RMS_AUTO_BIT];
            end
            if (aux_code_valid_i) begin
                aux4_q <= aux_four_ch_i;
            end
        end
    end

    // audio mode: auto takes the aux code, else the override gates bit 0
    wire reg_four = dpc_q[dam_pkg::DPC_OVR4_BIT] & dpc_q[dam_pkg::DPC_FOURCH_BIT];
    wire want_four = auto_q ? aux4_q : reg_four;
    // surround cannot ride with 18-bit video in repeater mode
    wire no_surround = rpt_q & dpc_q[dam_pkg::DPC_V18_BIT];

    assign dat_o = rdata_q;
    assign ack_o = ack_q;
    assign suppress_packet_audio_on_video_o = dpc_q[dam_pkg::DPC_SUPPRESS_BIT];
    assign four_ch_audio_o = want_four & ~no_surround;
    assign surround_refused_o = want_four & no_surround;
    assign video_18bit_o = dpc_q[dam_pkg::DPC_V18_BIT];
    assign inband_audio_o = dpc_q[dam_pkg::DPC_INBAND_BIT];
    // fast overrides the select bit; rate changes glitch the link briefly
    assign return_link_rate_o = fast_q ? dam_pkg::DAM_RATE_20M :
        (rate_q ? dam_pkg::DAM_RATE_10M : dam_pkg::DAM_RATE_5M);
    assign coax_mode_o = coax_q;
    assign repeater_mode_o = rpt_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    fc_load_a: assert property (
        fc_load_i.valid && !hold && !wr_dpc |=> dpc_q[4:0] == $past(fc_load_i.bits))
        else $error("forward load not taken");
    fc_block_a: assert property (
        fc_load_i.valid && hold && !wr_dpc |=> $stable(dpc_q))
        else $error("forward load passed while held");
    four_gate_a: assert property (
        !auto_q && !dpc_q[dam_pkg::DPC_OVR4_BIT] |-> !four_ch_audio_o)
        else $error("4-channel audio not forced off");
    surround_a: assert property (
        rpt_q && video_18bit_o |-> !four_ch_audio_o)
        else $error("surround allowed in repeater 18-bit");
    rate_sel_a: assert property (
        !fast_q |-> return_link_rate_o == (rate_q ? dam_pkg::DAM_RATE_10M : dam_pkg::DAM_RATE_5M))
        else $error("return link rate wrong");
    fast_rate_a: assert property (
        fast_q |-> return_link_rate_o == dam_pkg::DAM_RATE_20M)
        else $error("fast link not at 20M");
    auto_reset_a: assert property (
        $fell(rst_i) |-> auto_q)
        else $error("auto audio not set after reset");
    strap_a: assert property (
        !wr_rms |=> $stable(rpt_q))
        else $error("repeater bit changed");
    rms_read_a: assert property (
        req && !we_i && !ack_q && hit_rms |=> ack_o && dat_o[7] == 1'b0 && dat_o[1:0] == 2'b00)
        else $error("reserved bits not zero");
    suppress_a: assert property (
        wr_dpc |=> suppress_packet_audio_on_video_o == $past(dat_i[4]))
        else $error("suppress bit not written");
    ack_pulse_a: assert property (
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");

    // bus answer timing; one wait state, then the answer
    ack_resp_a: assert property (
        req && !ack_q |=> ack_o)
        else $error("request not acknowledged");

    // upper read lanes carry nothing, one byte per word
    rdata_upper_a: assert property (
        ack_o |-> dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    // unmapped reads answer zero instead of an error
    unmapped_read_a: assert property (
        req && !we_i && !ack_q && !hit_dpc && !hit_rms |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // repeater bit is visible on the bus
    rpt_read_a: assert property (
        req && !we_i && !ack_q && hit_rms |=> dat_o[2] == rpt_q)
        else $error("repeater bit not read back");

    // software write lands whole, hold bit included
    hold_write_a: assert property (
        wr_dpc |=> dpc_q == $past(dat_i[7:0]))
        else $error("datapath write not stored");

    hold_keep_a: assert property (
        hold && !wr_dpc |=> $stable(dpc_q))
        else $error("held register changed");

    // without a load or a write nothing moves
    idle_keep_a: assert property (
        !fc_load_i.valid && !wr_dpc |=> $stable(dpc_q))
        else $error("datapath changed while idle");

    // forward load leaves the hold and upper bits alone
    fc_keep_top_a: assert property (
        fc_take && !wr_dpc |=> dpc_q[7:5] == $past(dpc_q[7:5]))
        else $error("forward load touched upper bits");

    fc_suppress_a: assert property (
        fc_take && !wr_dpc |=> suppress_packet_audio_on_video_o == $past(fc_load_i.bits[4]))
        else $error("forward load suppress bit wrong");

    fc_v18_a: assert property (
        fc_take && !wr_dpc |=> video_18bit_o == $past(fc_load_i.bits[2]))
        else $error("forward load video width wrong");

    fc_inband_a: assert property (
        fc_take && !wr_dpc |=> inband_audio_o == $past(fc_load_i.bits[1]))
        else $error("forward load transport wrong");

    // field outputs follow a software write
    v18_write_a: assert property (
        wr_dpc |=> video_18bit_o == $past(dat_i[2]))
        else $error("video width not written");

    inband_write_a: assert property (
        wr_dpc |=> inband_audio_o == $past(dat_i[1]))
        else $error("transport select not written");

    four_write_a: assert property (
        wr_dpc && !auto_q && !rpt_q |=> four_ch_audio_o == ($past(dat_i[3]) && $past(dat_i[0])))
        else $error("4-channel enable not written");

    four_off_a: assert property (
        !auto_q && !dpc_q[dam_pkg::DPC_FOURCH_BIT] |-> !four_ch_audio_o)
        else $error("4-channel audio on while disabled");

    // refusal flag only for the unsupported mix
    refuse_flag_a: assert property (
        surround_refused_o |-> rpt_q && video_18bit_o)
        else $error("refusal flagged without cause");

    refuse_only_a: assert property (
        four_ch_audio_o |-> !surround_refused_o)
        else $error("audio on and refused together");

    // auto mode takes the last aux code seen
    auto_follow_a: assert property (
        auto_q && !(rpt_q && video_18bit_o) |-> four_ch_audio_o == aux4_q)
        else $error("auto audio not following aux code");

    aux_latch_a: assert property (
        aux_code_valid_i |=> aux4_q == $past(aux_four_ch_i))
        else $error("aux code not latched");

    auto_write_a: assert property (
        wr_rms |=> auto_q == $past(dat_i[dam_pkg::RMS_AUTO_BIT]))
        else $error("auto audio bit not written");

    // receive mode writes; repeater bit stays read-only
    rate_write_a: assert property (
        wr_rms |=> rate_q == $past(dat_i[dam_pkg::RMS_RATE_BIT]))
        else $error("rate select not written");

    fast_write_a: assert property (
        wr_rms |=> fast_q == $past(dat_i[dam_pkg::RMS_FAST_BIT]))
        else $error("fast bit not written");

    coax_write_a: assert property (
        wr_rms |=> coax_mode_o == $past(dat_i[dam_pkg::RMS_COAX_BIT]))
        else $error("coax bit not written");

    coax_keep_a: assert property (
        !wr_rms |=> $stable(coax_q))
        else $error("coax bit changed without write");

    // straps seen at the last reset edge, not a constant
    fast_strap_a: assert property (
        $fell(rst_i) |-> fast_q == $past(strap_select_pin_i.fast))
        else $error("fast bit not from strap");

    coax_strap_a: assert property (
        $fell(rst_i) |-> coax_q == $past(strap_select_pin_i.coax))
        else $error("coax bit not from strap");

    rpt_strap_a: assert property (
        $fell(rst_i) |-> rpt_q == $past(strap_select_pin_i.repeater))
        else $error("repeater bit not from strap");

    // main scenarios worth seeing in a run

    fc_seen_c: cover property (fc_load_i.valid && !hold);
    hold_c: cover property (wr_dpc && dat_i[7] ##1 fc_load_i.valid);
    refused_c: cover property (surround_refused_o);
    fast_c: cover property (wr_rms && dat_i[4]);
    auto_c: cover property (aux_code_valid_i && auto_q);
endmodule

/* dv/dam_ser_model.sv */
// remote serializer stand-in: forward-channel loads into the datapath bits
`timescale 1ns/100ps
module dam_ser_model (
    input wire logic clk_i,
    output dam_pkg::dam_fc_type fc_o
);
    initial fc_o = '0;
    // one-cycle load; idle bits flip so stale data never looks valid
    task automatic send(input logic [4:0] b);
        @(posedge clk_i);
        fc_o <= {1'b1, b};
        @(posedge clk_i);
        fc_o <= {1'b0, ~b};
    endtask
endmodule

/* dv/dam_regs_tb_top.sv */
// bench for the datapath and receive mode registers
`timescale 1ns/100ps
module dam_regs_tb_top;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, av = 0, af = 0;
    logic [7:0] adr = '0, q;
    logic [31:0] wd = '0, rd;
    logic s, f, r, v, ib, cx, rp;
    dam_pkg::dam_fc_type fc;
    dam_pkg::dam_rate_type rate;
    int mismatches = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    dam_ser_model i_dam_ser_model (.clk_i(clk), .fc_o(fc));
    dam_regs i_dam_regs (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'h1), .dat_i(wd), .dat_o(rd), .ack_o(ack),
        .strap_select_pin_i(3'b101), .fc_load_i(fc), .aux_code_valid_i(av),
        .aux_four_ch_i(af), .suppress_packet_audio_on_video_o(s), .four_ch_audio_o(f),
        .surround_refused_o(r), .video_18bit_o(v), .inband_audio_o(ib),
        .return_link_rate_o(rate), .coax_mode_o(cx), .repeater_mode_o(rp));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // one classic cycle; ack is looked at where it has settled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {1'b1, 1'b1, w, a, 24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rd[7:0];
        if (n >= 20) chk("ack", 8'h01, 8'h00);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        wb(0, a, 8'h00);
        chk("read", e, q);
    endtask
    // outputs packed as suppress, four_ch, refused, 18-bit, in-band
    task automatic outs(input logic [4:0] e);
        @(negedge clk);
        chk("outs", {3'h0, e}, {3'h0, s, f, r, v, ib});
    endtask
    task automatic chk_rate(input dam_pkg::dam_rate_type e);
        @(negedge clk);
        chk("rate", {6'h0, e}, {6'h0, rate});
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        rdc(8'h8c, 8'h34);
        chk("strap", 8'h01, {6'h0, cx, rp});
        chk_rate(dam_pkg::DAM_RATE_20M);
        rdc(8'h88, 8'h00);
        rdc(8'h00, 8'h00);
        wb(1, 8'h8c, 8'h00);
        chk_rate(dam_pkg::DAM_RATE_5M);
        i_dam_ser_model.send(5'h05);
        outs(5'b00010);
        rdc(8'h88, 8'h05);
        wb(1, 8'h8c, 8'hc7);
        rdc(8'h8c, 8'h44);
        chk_rate(dam_pkg::DAM_RATE_10M);
        wb(1, 8'h88, 8'h9b);
        outs(5'b11001);
        i_dam_ser_model.send(5'h00);
        rdc(8'h88, 8'h9b);
        wb(1, 8'h88, 8'h8d);
        outs(5'b00110);
        wb(1, 8'h8c, 8'h20);
        @(posedge clk);
        {av, af} <= 2'b11;
        @(posedge clk);
        av <= 0;
        wb(1, 8'h88, 8'h80);
        outs(5'b01000);
        tally_and_finish;
    end
endmodule
